// ===== scan_seq_params.svh
// Register offsets, field positions, reset values and limits of the sequencer.
`ifndef SCAN_SEQ_PARAMS_SVH
`define SCAN_SEQ_PARAMS_SVH
`define OFF_CMD 8'h00
`define OFF_PARAM 8'h04
`define OFF_STATUS 8'h08
`define OFF_ERR 8'h0C
`define OFF_RESP 8'h10
`define OFF_SETUP 8'h14
`define CMD_OP_LSB 0
`define CMD_FORM_LSB 4
`define ERR_BAD_PARAM 0
`define ERR_CONFLICT 1
`define ERR_BAD_CMD 2
`define MI_RST 9'h001
`define SA_RST 5'h0A
`define SA_MIN 32'h0000000A
`define SA_MAX 32'h00000019
`define SCAN_MAX 32'h000000FF
`define GAIN_MAX 32'h01312D00
`define BIAS_MAX 32'h000009BA
`define TOTAL_PRESSURE_ENABLE_RST 1'b1
`endif

// ===== scan_seq_pkg.sv
// Types shared by the analog scan command sequencer.
package scan_seq_pkg;
   typedef enum logic [3:0] {
      OP_SCAN = 4'h0, OP_TP = 4'h1, OP_GAIN = 4'h2, OP_BIAS = 4'h3,
      OP_MI = 4'h4, OP_MF = 4'h5, OP_SA = 4'h6, OP_NF = 4'h7, OP_HV = 4'h8
   } op_t;
   typedef enum logic [1:0] {
      FORM_NONE = 2'h0, FORM_VALUE = 2'h1, FORM_DEFAULT = 2'h2,
      FORM_QUERY = 2'h3
   } form_t;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01, ST_DRAIN = 5'h02, ST_ZERO = 5'h04,
      ST_STEP = 5'h08, ST_TOTAL = 5'h10
   } state_t;
   typedef enum logic [1:0] {
      KIND_ZERO = 2'h0, KIND_STEP = 2'h1, KIND_TOTAL = 2'h2
   } kind_t;
endpackage

// ===== analog_scan_command_sequencer.sv
// Analog scan command sequencer with a classic Wishbone register slave.
// How it works
// - No parameter: scan continuously until next command.
// - Parameter zero runs no scan at all.
// - Parameter 1..255 runs that many scans.
// - Default symbol runs exactly one scan.
// - Scan sends (final-initial)*steps+1 currents.
// - Currents are 4-byte binary, LSB first.
// - Command during scan aborts, flushes buffer.
// - Interrupting command runs after the abort.
// - Zero and parameter check precede first step.
// - Total pressure value ends every scan.
// - Detector settings latched at scan trigger.
// - Scan waits until earlier data drained.
// - Flag clear sends null current, no measurement.
// - Flag set on reset, cleared by multiplier.
// - Total pressure command 0/1 writes flag.
// - Total pressure query returns one current.
// - Total pressure uses 1 amu RF, zero DC.
// - Bad forms of both commands are errors.
// - Gain stored up to 2000.0000, queryable.
// - Bias stored 0 to 2490 volts, queryable.
// - No multiplier option: gain/bias bad command.
// - Each step advances mass by 1/steps.
// - Initial above final is a conflict error.
//
// Local design decisions: the address map and the Wishbone register port.
`include "scan_seq_params.svh"
module analog_scan_command_sequencer #(
   parameter logic [8:0] M_MAX = 9'h064,
   parameter logic [3:0] NF_MAX = 4'h7,
   parameter int BUF_DEPTH = 8192
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic option_installed,
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic meas_req,
   output scan_seq_pkg::kind_t meas_kind,
   output logic [15:0] meas_pos,
   output logic [4:0] meas_sa,
   output logic [3:0] meas_nf,
   output logic meas_det,
   input wire logic meas_done,
   input wire logic [31:0] meas_value,
   output logic rf_1amu,
   output logic dc_zero,
   output logic det_on
);
   import scan_seq_pkg::*;
   localparam int AW = $clog2(BUF_DEPTH);
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      state_t st;
      logic pend;
      op_t pend_op;
      form_t pend_form;
      logic [31:0] pend_val;
      logic [31:0] param;
      logic [2:0] err;
      logic [31:0] resp;
      logic [8:0] mi;
      logic [8:0] mf;
      logic [4:0] sa;
      logic [3:0] nf;
      logic det;
      logic total_pressure_enable;
      logic [31:0] gain;
      logic [11:0] bias;
      logic scanning;
      logic cont;
      logic [7:0] left;
      logic [15:0] npts;
      logic [15:0] step;
      logic [AW:0] wr;
      logic [AW:0] rd;
      logic [7:0] tx_data;
      logic tx_valid;
      logic [23:0] tx_sh;
      logic [1:0] tx_left;
      logic req;
      kind_t kind;
      logic [15:0] pos;
      logic [4:0] l_sa;
      logic [3:0] l_nf;
      logic l_det;
      logic rf;
      logic dc;
   } state_reg_t;
   state_reg_t s_reg;
   state_reg_t s_next;
   logic [31:0] mem [BUF_DEPTH];
   logic [31:0] rd_word;
   logic empty;
   logic bus_wr;
   logic push;
   logic [31:0] push_val;
   logic total_end;
   logic start_scan;
   logic hv_on;
   logic [2:0] err_set;
   logic [2:0] err_clr;
   assign rd_word = mem[s_reg.rd[AW-1:0]];
   assign empty = (s_reg.rd == s_reg.wr);
   assign bus_wr = s_reg.ack & wb_cyc_i & wb_stb_i & wb_we_i
      & (wb_sel_i == 4'hF);
   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next = s_reg;
      push = 1'b0;
      push_val = 32'h00000000;
      total_end = 1'b0;
      start_scan = 1'b0;
      hv_on = 1'b0;
      err_set = 3'h0;
      err_clr = 3'h0;
      // Bus slave: one-cycle ack, write committed on the ack edge.
      s_next.ack = wb_cyc_i & wb_stb_i & ~s_reg.ack;
      s_next.dat = 32'h00000000;
      if (s_next.ack && !wb_we_i) begin
         case (wb_adr_i)
            `OFF_PARAM: s_next.dat = s_reg.param;
            `OFF_STATUS: s_next.dat = {8'h00, s_reg.left, 6'h00,
               s_reg.det, s_reg.scanning, s_reg.pend, empty,
               s_reg.total_pressure_enable, s_reg.st};
            `OFF_ERR: s_next.dat = {29'h0, s_reg.err};
            `OFF_RESP: s_next.dat = s_reg.resp;
            `OFF_SETUP: s_next.dat = {4'h0, s_reg.det, s_reg.nf,
               s_reg.sa, s_reg.mf, s_reg.mi};
            default: s_next.dat = 32'h00000000;
         endcase
      end
      if (bus_wr && wb_adr_i == `OFF_PARAM) begin
         s_next.param = wb_dat_i;
      end
      if (bus_wr && wb_adr_i == `OFF_ERR) begin
         err_clr = wb_dat_i[2:0];
      end
      // Byte serializer drains the buffer, low byte first.
      if (!s_reg.tx_valid || tx_ready) begin
         if (s_reg.tx_left != 2'h0) begin
            s_next.tx_data = s_reg.tx_sh[7:0];
            s_next.tx_sh = {8'h00, s_reg.tx_sh[23:8]};
            s_next.tx_left = s_reg.tx_left - 2'h1;
            s_next.tx_valid = 1'b1;
         end else if (!empty) begin
            s_next.tx_data = rd_word[7:0];
            s_next.tx_sh = rd_word[31:8];
            s_next.tx_left = 2'h3;
            s_next.tx_valid = 1'b1;
            s_next.rd = s_reg.rd + (AW+1)'(1);
         end else begin
            s_next.tx_valid = 1'b0;
         end
      end
      ////////////////////////////////////////////////////////////////////
      if (s_reg.st != ST_IDLE && s_reg.pend) begin
         s_next.st = ST_IDLE;
         s_next.req = 1'b0;
         s_next.rf = 1'b0;
         s_next.dc = 1'b0;
         s_next.scanning = 1'b0;
         s_next.rd = s_reg.wr;
         s_next.tx_valid = 1'b0;
         s_next.tx_left = 2'h0;
      end else begin
         case (s_reg.st)
            ST_IDLE: begin
               if (s_reg.pend) begin
                  s_next.pend = 1'b0;
                  case (s_reg.pend_op)
                     OP_SCAN: begin
                        case (s_reg.pend_form)
                           FORM_NONE: begin
                              s_next.cont = 1'b1;
                              start_scan = 1'b1;
                           end
                           FORM_VALUE: begin
                              if (s_reg.pend_val > `SCAN_MAX) begin
                                 err_set[`ERR_BAD_PARAM] = 1'b1;
                              end else if (s_reg.pend_val != 0) begin
                                 s_next.cont = 1'b0;
                                 s_next.left = s_reg.pend_val[7:0];
                                 start_scan = 1'b1;
                              end
                           end
                           FORM_DEFAULT: begin
                              s_next.cont = 1'b0;
                              s_next.left = 8'h01;
                              start_scan = 1'b1;
                           end
                           default: err_set[`ERR_BAD_PARAM] = 1'b1;
                        endcase
                     end
                     OP_TP: begin
                        if (s_reg.pend_form == FORM_QUERY) begin
                           s_next.st = ST_TOTAL;
                        end else if (s_reg.pend_form == FORM_VALUE
                           && s_reg.pend_val < 32'h00000002) begin
                           s_next.total_pressure_enable = s_reg.pend_val[0];
                        end else begin
                           err_set[`ERR_BAD_PARAM] = 1'b1;
                        end
                     end
                     OP_GAIN, OP_BIAS: begin
                        if (!option_installed) begin
                           err_set[`ERR_BAD_CMD] = 1'b1;
                        end else if (s_reg.pend_form == FORM_QUERY) begin
                           s_next.resp = (s_reg.pend_op == OP_GAIN)
                              ? s_reg.gain : {20'h0, s_reg.bias};
                        end else if (s_reg.pend_form != FORM_VALUE) begin
                           err_set[`ERR_BAD_PARAM] = 1'b1;
                        end else if (s_reg.pend_op == OP_GAIN) begin
                           if (s_reg.pend_val > `GAIN_MAX) begin
                              err_set[`ERR_BAD_PARAM] = 1'b1;
                           end else begin
                              s_next.gain = s_reg.pend_val;
                           end
                        end else if (s_reg.pend_val > `BIAS_MAX) begin
                           err_set[`ERR_BAD_PARAM] = 1'b1;
                        end else begin
                           s_next.bias = s_reg.pend_val[11:0];
                        end
                     end
                     OP_MI, OP_MF: begin
                        if (s_reg.pend_form == FORM_QUERY) begin
                           s_next.resp = {23'h0, (s_reg.pend_op == OP_MI)
                              ? s_reg.mi : s_reg.mf};
                        end else if (s_reg.pend_form == FORM_DEFAULT) begin
                           if (s_reg.pend_op == OP_MI) begin
                              s_next.mi = `MI_RST;
                           end else begin
                              s_next.mf = M_MAX;
                           end
                        end else if (s_reg.pend_form == FORM_NONE
                           || s_reg.pend_val == 0
                           || s_reg.pend_val > 32'(M_MAX)) begin
                           err_set[`ERR_BAD_PARAM] = 1'b1;
                        end else if (s_reg.pend_op == OP_MI) begin
                           if (s_reg.pend_val[8:0] > s_reg.mf) begin
                              err_set[`ERR_CONFLICT] = 1'b1;
                           end else begin
                              s_next.mi = s_reg.pend_val[8:0];
                           end
                        end else if (s_reg.pend_val[8:0] < s_reg.mi) begin
                           err_set[`ERR_CONFLICT] = 1'b1;
                        end else begin
                           s_next.mf = s_reg.pend_val[8:0];
                        end
                     end
                     OP_SA: begin
                        if (s_reg.pend_form == FORM_QUERY) begin
                           s_next.resp = {27'h0, s_reg.sa};
                        end else if (s_reg.pend_form == FORM_DEFAULT) begin
                           s_next.sa = `SA_RST;
                        end else if (s_reg.pend_form == FORM_VALUE
                           && s_reg.pend_val >= `SA_MIN
                           && s_reg.pend_val <= `SA_MAX) begin
                           s_next.sa = s_reg.pend_val[4:0];
                        end else begin
                           err_set[`ERR_BAD_PARAM] = 1'b1;
                        end
                     end
                     OP_NF: begin
                        if (s_reg.pend_form == FORM_QUERY) begin
                           s_next.resp = {28'h0, s_reg.nf};
                        end else if (s_reg.pend_form == FORM_VALUE
                           && s_reg.pend_val <= 32'(NF_MAX)) begin
                           s_next.nf = s_reg.pend_val[3:0];
                        end else begin
                           err_set[`ERR_BAD_PARAM] = 1'b1;
                        end
                     end
                     OP_HV: begin
                        if (s_reg.pend_form == FORM_QUERY) begin
                           s_next.resp = {31'h0, s_reg.det};
                        end else if (s_reg.pend_form == FORM_VALUE) begin
                           s_next.det = (s_reg.pend_val != 0);
                           if (s_reg.pend_val != 0) begin
                              hv_on = 1'b1;
                              s_next.total_pressure_enable = 1'b0;
                           end
                        end else begin
                           err_set[`ERR_BAD_PARAM] = 1'b1;
                        end
                     end
                     default: err_set[`ERR_BAD_CMD] = 1'b1;
                  endcase
               end
            end
            ST_DRAIN: begin
               if (empty) begin
                  s_next.st = ST_ZERO;
               end
            end
            ST_ZERO: begin
               if (!s_reg.req) begin
                  s_next.req = 1'b1;
                  s_next.kind = KIND_ZERO;
               end else if (meas_done) begin
                  s_next.req = 1'b0;
                  s_next.step = 16'h0000;
                  s_next.pos = {7'h00, s_reg.mi} * {11'h000, s_reg.l_sa};
                  s_next.st = ST_STEP;
               end
            end
            ST_STEP: begin
               if (!s_reg.req) begin
                  s_next.req = 1'b1;
                  s_next.kind = KIND_STEP;
               end else if (meas_done) begin
                  s_next.req = 1'b0;
                  push = 1'b1;
                  push_val = meas_value;
                  if (s_reg.step == s_reg.npts - 16'h0001) begin
                     s_next.st = ST_TOTAL;
                  end else begin
                     s_next.step = s_reg.step + 16'h0001;
                     s_next.pos = s_reg.pos + 16'h0001;
                  end
               end
            end
            ST_TOTAL: begin
               if (!s_reg.total_pressure_enable) begin
                  push = 1'b1;
                  total_end = 1'b1;
               end else if (!s_reg.req) begin
                  s_next.req = 1'b1;
                  s_next.kind = KIND_TOTAL;
                  s_next.rf = 1'b1;
                  s_next.dc = 1'b1;
               end else if (meas_done) begin
                  s_next.req = 1'b0;
                  s_next.rf = 1'b0;
                  s_next.dc = 1'b0;
                  push = 1'b1;
                  push_val = meas_value;
                  total_end = 1'b1;
               end
            end
            default: s_next.st = ST_IDLE;
         endcase
      end
      if (start_scan) begin
         s_next.scanning = 1'b1;
         s_next.l_sa = s_reg.sa;
         s_next.l_nf = s_reg.nf;
         s_next.l_det = s_reg.det;
         s_next.npts = ({7'h00, 9'(s_reg.mf - s_reg.mi)}
            * {11'h000, s_reg.sa}) + 16'h0001;
         s_next.st = ST_DRAIN;
      end
      if (total_end) begin
         if (s_reg.scanning && (s_reg.cont || s_reg.left > 8'h01)) begin
            s_next.left = s_reg.cont ? s_reg.left : s_reg.left - 8'h01;
            s_next.st = ST_DRAIN;
         end else begin
            s_next.scanning = 1'b0;
            s_next.st = ST_IDLE;
         end
      end
      if (push) begin
         s_next.wr = s_reg.wr + (AW+1)'(1);
      end
      s_next.err = (s_reg.err & ~err_clr) | err_set;
      if (bus_wr && wb_adr_i == `OFF_CMD) begin
         s_next.pend = 1'b1;
         s_next.pend_op = op_t'(wb_dat_i[`CMD_OP_LSB +: 4]);
         s_next.pend_form = form_t'(wb_dat_i[`CMD_FORM_LSB +: 2]);
         s_next.pend_val = s_reg.param;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
         s_reg.st <= ST_IDLE;
         s_reg.mi <= `MI_RST;
         s_reg.mf <= M_MAX;
         s_reg.sa <= `SA_RST;
         s_reg.total_pressure_enable <= `TOTAL_PRESSURE_ENABLE_RST;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end
   always_ff @(posedge clock) begin
      if (ce && push) begin
         mem[s_reg.wr[AW-1:0]] <= push_val;
      end
   end
   assign wb_dat_o = s_reg.dat;
   assign wb_ack_o = s_reg.ack;
   assign tx_data = s_reg.tx_data;
   assign tx_valid = s_reg.tx_valid;
   assign meas_req = s_reg.req;
   assign meas_kind = s_reg.kind;
   assign meas_pos = s_reg.pos;
   assign meas_sa = s_reg.l_sa;
   assign meas_nf = s_reg.l_nf;
   assign meas_det = s_reg.l_det;
   assign rf_1amu = s_reg.rf;
   assign dc_zero = s_reg.dc;
   assign det_on = s_reg.det;
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b || !ce);
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Bus ack held longer than one cycle.");
   abort_flush_a: assert property (s_reg.st != ST_IDLE && s_reg.pend
      |=> s_reg.st == ST_IDLE && empty && !tx_valid)
      else $error("Command during scan did not flush the buffer.");
   null_total_a: assert property (s_reg.st == ST_TOTAL
      && !s_reg.total_pressure_enable && !s_reg.pend |-> push && push_val == 0 && !meas_req)
      else $error("Cleared flag did not send a null current.");
   tp_bias_a: assert property (rf_1amu |-> dc_zero
      && meas_kind == KIND_TOTAL)
      else $error("Total pressure filter settings wrong.");
   drain_first_a: assert property (s_reg.st == ST_DRAIN
      ##1 s_reg.st == ST_ZERO |-> $past(empty))
      else $error("Scan started with data pending.");
   hv_clear_a: assert property (hv_on |=> !s_reg.total_pressure_enable)
      else $error("Multiplier on did not clear the flag.");
   last_step_a: assert property (s_reg.st == ST_STEP && meas_req
      && meas_done && !s_reg.pend && s_reg.step == s_reg.npts - 16'h0001
      |=> s_reg.st == ST_TOTAL && (s_reg.total_pressure_enable || s_reg.pend || push))
      else $error("Last step did not lead to total pressure.");
   zero_first_a: assert property ($rose(s_reg.st == ST_STEP)
      |-> $past(s_reg.st == ST_ZERO))
      else $error("Step entered without zero check.");
   req_hold_a: assert property (meas_req && !meas_done && !s_reg.pend
      |=> meas_req)
      else $error("Measurement request dropped early.");
   loop_c: cover property (s_reg.cont && s_reg.st == ST_TOTAL
      ##1 s_reg.st == ST_DRAIN);
   abort_c: cover property (s_reg.st == ST_STEP && s_reg.pend);
   tp_query_c: cover property (!s_reg.scanning && s_reg.st == ST_TOTAL
      && meas_done);
endmodule

// ===== scan_front_end_model.sv
// Front end and serial sink model facing the scan sequencer.
module scan_front_end_model (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic meas_req,
   input wire scan_seq_pkg::kind_t meas_kind,
   input wire logic [15:0] meas_pos,
   input wire logic rf_1amu,
   input wire logic dc_zero,
   output logic meas_done,
   output logic [31:0] meas_value,
   output logic tx_ready,
   output logic tp_bad
);
   timeunit 1ns;
   timeprecision 1ns;
   import scan_seq_pkg::*;
   logic [2:0] wait_cnt;
   logic [1:0] rdy_cnt;
   logic slow;
   // Answers alternate fast and slow; the sink stalls one cycle in four.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         meas_done <= 1'b0;
         meas_value <= 32'h00000000;
         wait_cnt <= 3'h0;
         rdy_cnt <= 2'h0;
         slow <= 1'b0;
         tx_ready <= 1'b0;
         tp_bad <= 1'b0;
      end else begin
         rdy_cnt <= rdy_cnt + 2'h1;
         tx_ready <= rdy_cnt != 2'h3;
         if (meas_done) begin
            meas_done <= 1'b0;
            meas_value <= ~meas_value;
            slow <= ~slow;
         end else if (meas_req && wait_cnt != 3'h0) begin
            wait_cnt <= wait_cnt - 3'h1;
         end else if (meas_req) begin
            meas_done <= 1'b1;
            wait_cnt <= slow ? 3'h5 : 3'h0;
            meas_value <= meas_kind == KIND_TOTAL ? 32'h00C0FFEE :
               {16'hFFFF, meas_pos};
            tp_bad <= tp_bad |
               (meas_kind == KIND_TOTAL && !(rf_1amu && dc_zero));
         end
      end
   end
endmodule

// ===== analog_scan_command_sequencer_test.sv
// Self-checking bench for the analog scan command sequencer.
`include "scan_seq_params.svh"
module analog_scan_command_sequencer_test;
   timeunit 1ns;
   timeprecision 1ns;
   import scan_seq_pkg::*;
   logic clock, rst_b, ce, we, cyc, stb, ack, opt, tx_valid, tx_ready;
   logic req, done, rf, dcz, det, mdet, tp_bad;
   logic [7:0] adr, tx_data;
   logic [31:0] wdat, rdat, q, mval;
   logic [3:0] sel, nf;
   logic [15:0] pos;
   logic [4:0] sa;
   kind_t kind;
   logic [7:0] rx[$];
   int errors, checked, n;
   analog_scan_command_sequencer #(.BUF_DEPTH(64))
   analog_scan_command_sequencer_i (
      .clock(clock), .rst_b(rst_b), .ce(ce), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
      .option_installed(opt), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .meas_req(req), .meas_kind(kind),
      .meas_pos(pos), .meas_sa(sa), .meas_nf(nf), .meas_det(mdet),
      .meas_done(done), .meas_value(mval), .rf_1amu(rf), .dc_zero(dcz),
      .det_on(det));
   scan_front_end_model scan_front_end_model_i (
      .clock(clock), .rst_b(rst_b), .meas_req(req), .meas_kind(kind),
      .meas_pos(pos), .rf_1amu(rf), .dc_zero(dcz), .meas_done(done),
      .meas_value(mval), .tx_ready(tx_ready), .tp_bad(tp_bad));
   ////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clock);
      while (ack !== 1'b1) begin
         @(posedge clock);
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clock);
   endtask
   task automatic cmd(input op_t o, input form_t f, input logic [31:0] v);
      bus(`OFF_PARAM, 1'b1, v);
      bus(`OFF_CMD, 1'b1, {26'h0, f, o});
   endtask
   task automatic settle();
      int k;
      for (k = 0; k < 4000; k++) begin
         bus(`OFF_STATUS, 1'b0, 32'h0);
         if (q[4:0] === 5'h01 && q[8] === 1'b0 && q[6] === 1'b1 &&
             tx_valid === 1'b0) break;
      end
      if (k == 4000) errors++;
   endtask
   function automatic logic [31:0] word(input int i);
      return {rx[4 * i + 3], rx[4 * i + 2], rx[4 * i + 1], rx[4 * i]};
   endfunction
   task automatic scans(input int ns, input logic [31:0] tot);
      int s, k;
      check(32'(rx.size()), 32'(ns * 48));
      for (s = 0; s < ns; s++) begin
         for (k = 0; k < 11; k++)
            check(word(s * 12 + k), {16'hFFFF, 16'(20 + k)});
         check(word(s * 12 + 11), tot);
      end
      rx.delete();
   endtask
   task automatic err(input logic [31:0] e);
      bus(`OFF_ERR, 1'b0, 32'h0);
      check(q, e);
      bus(`OFF_ERR, 1'b1, 32'h00000007);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock)
      if (tx_valid === 1'b1 && tx_ready === 1'b1) rx.push_back(tx_data);
   initial begin
      repeat (80000) @(posedge clock);
      errors++;
      close_out();
   end
   initial begin
      errors = 0;
      checked = 0;
      rst_b = 1'b0;
      ce = 1'b1;
      {cyc, stb, we, opt} = 4'h0;
      sel = 4'hF;
      adr = 8'h00;
      wdat = 32'h0;
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      bus(`OFF_STATUS, 1'b0, 32'h0);
      check(q, 32'h00000061);
      cmd(OP_MF, FORM_VALUE, 32'h3);
      cmd(OP_MI, FORM_VALUE, 32'h2);
      bus(`OFF_SETUP, 1'b0, 32'h0);
      check(q, 32'h00280602);
      cmd(OP_SCAN, FORM_DEFAULT, 32'h0);
      settle();
      scans(1, 32'h00C0FFEE);
      cmd(OP_TP, FORM_VALUE, 32'h0);
      cmd(OP_SCAN, FORM_VALUE, 32'h2);
      settle();
      scans(2, 32'h0);
      cmd(OP_TP, FORM_QUERY, 32'h0);
      settle();
      cmd(OP_TP, FORM_VALUE, 32'h1);
      cmd(OP_TP, FORM_QUERY, 32'h0);
      settle();
      check(word(0), 32'h0);
      check(word(1), 32'h00C0FFEE);
      check(32'(rx.size()), 32'h8);
      rx.delete();
      cmd(OP_SCAN, FORM_VALUE, 32'h0);
      settle();
      check(32'(rx.size()), 32'h0);
      cmd(OP_SCAN, FORM_NONE, 32'h0);
      for (n = 0; n < 20000 && rx.size() < 120; n++) @(posedge clock);
      check(32'(rx.size() >= 120), 32'h1);
      cmd(OP_TP, FORM_VALUE, 32'h0);
      repeat (3) @(posedge clock);
      check(32'(tx_valid), 32'h0);
      n = rx.size();
      repeat (60) @(posedge clock);
      check(32'(rx.size() - n), 32'h0);
      bus(`OFF_STATUS, 1'b0, 32'h0);
      check(32'({q[8], q[5], q[4:0]}), 32'h01);
      rx.delete();
      cmd(OP_TP, FORM_NONE, 32'h0);
      err(32'h1);
      cmd(OP_SCAN, FORM_QUERY, 32'h0);
      err(32'h1);
      cmd(OP_SCAN, FORM_VALUE, 32'h100);
      err(32'h1);
      cmd(OP_MI, FORM_VALUE, 32'h4);
      err(32'h2);
      cmd(OP_SA, FORM_VALUE, 32'h1A);
      err(32'h1);
      cmd(OP_GAIN, FORM_QUERY, 32'h0);
      err(32'h4);
      opt <= 1'b1;
      cmd(OP_GAIN, FORM_VALUE, 32'h01312D00);
      cmd(OP_GAIN, FORM_QUERY, 32'h0);
      bus(`OFF_RESP, 1'b0, 32'h0);
      check(q, 32'h01312D00);
      cmd(OP_BIAS, FORM_VALUE, 32'h9BA);
      cmd(OP_BIAS, FORM_QUERY, 32'h0);
      bus(`OFF_RESP, 1'b0, 32'h0);
      check(q, 32'h000009BA);
      cmd(OP_BIAS, FORM_VALUE, 32'h9BB);
      err(32'h1);
      bus(8'h20, 1'b0, 32'h0);
      check(q, 32'h0);
      cmd(OP_TP, FORM_VALUE, 32'h1);
      bus(`OFF_STATUS, 1'b0, 32'h0);
      check(32'(q[5]), 32'h1);
      cmd(OP_HV, FORM_VALUE, 32'h1);
      bus(`OFF_STATUS, 1'b0, 32'h0);
      check(32'({det, q[9], q[5]}), 32'h6);
      cmd(OP_NF, FORM_VALUE, 32'h3);
      cmd(OP_SCAN, FORM_DEFAULT, 32'h0);
      settle();
      scans(1, 32'h0);
      cmd(OP_NF, FORM_VALUE, 32'h5);
      cmd(OP_NF, FORM_QUERY, 32'h0);
      bus(`OFF_RESP, 1'b0, 32'h0);
      check(q, 32'h00000005);
      check(32'({mdet, nf, sa}), 32'h0000026A);
      check(32'(tp_bad), 32'h0);
      close_out();
   end
endmodule
